// file: rtl/ddifm_regs.svh
// Register offsets, field positions, reset values and function indices of the input map.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef DDIFM_REGS_SVH
`define DDIFM_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define DDIFM_NFUNC 29
`define DDIFM_NTERM 6

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DDIFM_OFF_CFG 12'h000
`define DDIFM_OFF_STATUS 12'h004
`define DDIFM_OFF_TERMS 12'h008
`define DDIFM_OFF_LEVELS 12'h00C
`define DDIFM_OFF_SEL_BASE 12'h040
`define DDIFM_OFF_SEL_LAST 12'h0B0

// ----------------------------------------
// Configuration fields and reset values
// ----------------------------------------
`define DDIFM_CFG_PLACE_LSB 0
`define DDIFM_CFG_PREHEAT_LSB 4
`define DDIFM_CFG_PIDEN_BIT 8
`define DDIFM_PREHEAT_BY_INPUT 2'h2
`define DDIFM_RST_PLACE 2'h0
`define DDIFM_RST_PREHEAT 2'h0
`define DDIFM_RST_PIDEN 1'h0
`define DDIFM_RST_TIMER_PREV 3'h7

// ----------------------------------------
// Source selector encoding: slot in [7:4], index in [3:0]
// ----------------------------------------
`define DDIFM_SLOT_VIRT 4'h0
`define DDIFM_SLOT_A 4'h1
`define DDIFM_IDX_FALSE 4'h1
`define DDIFM_IDX_TRUE 4'h2
`define DDIFM_SEL_OFF 8'h01
`define DDIFM_SEL_ON 8'h02
`define DDIFM_SEL_T1 8'h11
`define DDIFM_SEL_T2 8'h12
`define DDIFM_SEL_T3 8'h13
`define DDIFM_SEL_T4 8'h14
`define DDIFM_SEL_T5 8'h15
`define DDIFM_SEL_T6 8'h16

// ----------------------------------------
// Function indices (selector n sits at SEL_BASE + 4*n)
// ----------------------------------------
`define DDIFM_F_A1 0
`define DDIFM_F_A2 1
`define DDIFM_F_A3 2
`define DDIFM_F_B1 3
`define DDIFM_F_B2 4
`define DDIFM_F_B3 5
`define DDIFM_F_FORCE_B 6
`define DDIFM_F_REF_B 7
`define DDIFM_F_FORCE_FB 8
`define DDIFM_F_FORCE_KP 9
`define DDIFM_F_FLT_NO 10
`define DDIFM_F_FLT_NC 11
`define DDIFM_F_RST_NO 12
`define DDIFM_F_RST_NC 13
`define DDIFM_F_RUN_EN 14
`define DDIFM_F_ILK1 15
`define DDIFM_F_ILK2 16
`define DDIFM_F_PREHEAT 17
`define DDIFM_F_RAMP2 18
`define DDIFM_F_HOLD 19
`define DDIFM_F_PS0 20
`define DDIFM_F_PS1 21
`define DDIFM_F_PS2 22
`define DDIFM_F_POT_UP 23
`define DDIFM_F_POT_DN 24
`define DDIFM_F_TMR1 25
`define DDIFM_F_TMR2 26
`define DDIFM_F_TMR3 27
`define DDIFM_F_PID 28

`endif

// file: rtl/ddifm_pkg.sv
// Types shared by the digital input map.
// Assumes the constants header sits on the include path.
`include "ddifm_regs.svh"

package ddifm_pkg;

    // ----------------------------------------
    // Control place
    // ----------------------------------------
    typedef enum logic [1:0] {
        DDIFM_PLACE_A = 2'b00,
        DDIFM_PLACE_B = 2'b01,
        DDIFM_PLACE_KEYPAD = 2'b10,
        DDIFM_PLACE_FIELDBUS = 2'b11
    } ddifm_place_t;

    // ----------------------------------------
    // Whole state of the map
    // ----------------------------------------
    typedef struct packed {
        logic [`DDIFM_NFUNC-1:0][7:0] sel;
        ddifm_place_t cfg_place;
        logic [1:0] cfg_preheat;
        logic cfg_pid_en;
        logic [2:0] timer_prev;
        logic fault_latched;
        logic [31:0] prdata;
        logic pslverr;
        logic [2:0] start;
        ddifm_place_t place;
        logic ref_b;
        logic ext_fault;
        logic fault_reset;
        logic ready;
        logic start_blocked;
        logic preheat;
        logic ramp_two;
        logic ramp_hold;
        logic [2:0] preset;
        logic pot_up;
        logic pot_down;
        logic [2:0] timer_start;
        logic pid_run;
    } ddifm_state_t;

endpackage

// file: rtl/ddifm_src_mux.sv
// One function's source selector: picks a terminal or a constant pseudo-input.
// Assumes terminal levels are already synchronous to the clock.
`timescale 1ns/1ps
`include "ddifm_regs.svh"

module ddifm_src_mux
(
    // Selector and terminals
    input wire logic [7:0] sel,
    input wire logic [`DDIFM_NTERM-1:0] terms,
    // Selected level
    output logic level
);
    import ddifm_pkg::*;

    logic [3:0] slot;
    logic [3:0] idx;

    assign slot = sel[7:4];
    assign idx = sel[3:0];

    // Unknown slots and indices read false, so a bad selector never starts the motor.
    always_comb
    begin
        level = 1'b0;
        if (slot == `DDIFM_SLOT_VIRT)
        begin
            level = (idx == `DDIFM_IDX_TRUE);
        end
        else if (slot == `DDIFM_SLOT_A && idx >= 4'h1 && idx <= 4'h6)
        begin
            level = terms[3'(idx - 4'h1)];
        end
    end
endmodule

// file: rtl/ddifm_top.sv
// Digital input function map of a drive controller, with an APB register slave.
// Assumes terminal inputs are synchronous to ref_clk and debounced outside.
//
// Summary of operation
// - After reset terminals one to six feed A1, A2, fault, preset bits, fault reset.
// - Every function has a slot and index selector choosing its physical input.
// - With place A active, control input one is the forward run command.
// - With place A active, control input two is the reverse run command.
// - With place B active, start commands come from the three place-B inputs.
// - The place-B force input overrides the configured control place.
// - The reference-B force input selects the place-B frequency reference source.
// - Fieldbus force and keypad force inputs move command control there.
// - Normally-open fault input true raises the external fault.
// - Normally-closed fault input false raises the external fault.
// - Normally-open fault reset true clears all active faults.
// - Normally-closed fault reset false clears all active faults.
// - Ready is reported only while run enable is asserted.
// - An active run interlock keeps ready but blocks every start command.
// - Preheat mode two plus preheat input true applies preheat while stopped.
// - Ramp select false picks ramp set one, true picks set two.
// - Ramp hold closed freezes acceleration and deceleration.
// - Three preset inputs form a binary code choosing speeds 0-7.
// - Potentiometer-up true keeps increasing the motor potentiometer reference.
// - Potentiometer-down true keeps decreasing the motor potentiometer reference.
// - A rising edge on each timer input starts its timer, never a level.
// - Process controller start input only matters while that controller is enabled.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "ddifm_regs.svh"

module ddifm_top
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Terminal inputs
    input wire logic terminal_input_one,
    input wire logic terminal_input_two,
    input wire logic terminal_input_three,
    input wire logic terminal_input_four,
    input wire logic terminal_input_five,
    input wire logic terminal_input_six,
    // Commands and control place
    output logic start_fwd,
    output logic start_rev,
    output logic start_third,
    output ddifm_pkg::ddifm_place_t cmd_place,
    output logic ref_source_b,
    // Faults and readiness
    output logic ext_fault,
    output logic fault_active,
    output logic fault_reset,
    output logic drive_ready,
    output logic start_blocked,
    // Motor functions
    output logic preheat_on,
    output logic ramp_set_two,
    output logic ramp_hold,
    output logic [2:0] preset_index,
    output logic pot_up,
    output logic pot_down,
    output logic [2:0] timer_start,
    output logic ext_pid_run
);
    import ddifm_pkg::*;

    // ----------------------------------------
    // Reset source map
    // ----------------------------------------
    function automatic logic [7:0] ddifm_dflt_sel(input int f);
        case (f)
            `DDIFM_F_A1: return `DDIFM_SEL_T1;
            `DDIFM_F_A2: return `DDIFM_SEL_T2;
            `DDIFM_F_FLT_NO: return `DDIFM_SEL_T3;
            `DDIFM_F_PS0: return `DDIFM_SEL_T4;
            `DDIFM_F_PS1: return `DDIFM_SEL_T5;
            `DDIFM_F_RST_NO: return `DDIFM_SEL_T6;
            `DDIFM_F_FLT_NC: return `DDIFM_SEL_ON;
            `DDIFM_F_RST_NC: return `DDIFM_SEL_ON;
            `DDIFM_F_RUN_EN: return `DDIFM_SEL_ON;
            `DDIFM_F_ILK1: return `DDIFM_SEL_ON;
            `DDIFM_F_ILK2: return `DDIFM_SEL_ON;
            `DDIFM_F_PID: return `DDIFM_SEL_ON;
            default: return `DDIFM_SEL_OFF;
        endcase
    endfunction

    ddifm_state_t st_reg;
    ddifm_state_t st_next;
    logic [`DDIFM_NTERM-1:0] terms;
    logic [`DDIFM_NFUNC-1:0] lv;
    logic [2:0] preset_lv;
    logic [2:0] timer_lv;

    assign terms = {terminal_input_six, terminal_input_five, terminal_input_four,
                    terminal_input_three, terminal_input_two, terminal_input_one};
    assign preset_lv = {lv[`DDIFM_F_PS2], lv[`DDIFM_F_PS1], lv[`DDIFM_F_PS0]};
    assign timer_lv = {lv[`DDIFM_F_TMR3], lv[`DDIFM_F_TMR2], lv[`DDIFM_F_TMR1]};

    // ----------------------------------------
    // Source selection
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `DDIFM_NFUNC; g++)
        begin : gen_src
            ddifm_src_mux u_mux
            (
                .sel(st_reg.sel[g]),
                .terms(terms),
                .level(lv[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        ddifm_place_t place_n;
        logic [2:0] cmd_n;
        logic permit_n;
        logic fault_n;
        logic [11:0] sel_off;
        logic sel_hit;
        place_n = st_reg.cfg_place;
        cmd_n = 3'h0;
        permit_n = 1'b0;
        fault_n = 1'b0;
        sel_off = paddr - `DDIFM_OFF_SEL_BASE;
        sel_hit = paddr >= `DDIFM_OFF_SEL_BASE && paddr <= `DDIFM_OFF_SEL_LAST
                  && paddr[1:0] == 2'h0;
        st_next = st_reg;

        // Keypad force outranks fieldbus force, which outranks the place-B force.
        if (lv[`DDIFM_F_FORCE_KP])
        begin
            place_n = DDIFM_PLACE_KEYPAD;
        end
        else if (lv[`DDIFM_F_FORCE_FB])
        begin
            place_n = DDIFM_PLACE_FIELDBUS;
        end
        else if (lv[`DDIFM_F_FORCE_B])
        begin
            place_n = DDIFM_PLACE_B;
        end

        unique case (place_n)
            DDIFM_PLACE_A:
            begin
                cmd_n = {lv[`DDIFM_F_A3], lv[`DDIFM_F_A2], lv[`DDIFM_F_A1]};
            end
            DDIFM_PLACE_B:
            begin
                cmd_n = {lv[`DDIFM_F_B3], lv[`DDIFM_F_B2], lv[`DDIFM_F_B1]};
            end
            DDIFM_PLACE_KEYPAD, DDIFM_PLACE_FIELDBUS:
            begin
                cmd_n = 3'h0;
            end
        endcase

        // Interlocks are permissive when true, so the tied-true reset source lets starts pass.
        st_next.start_blocked = !lv[`DDIFM_F_ILK1] || !lv[`DDIFM_F_ILK2];
        st_next.ready = lv[`DDIFM_F_RUN_EN];
        permit_n = st_next.ready && !st_next.start_blocked;
        st_next.start = permit_n ? cmd_n : 3'h0;
        st_next.place = place_n;
        st_next.ref_b = lv[`DDIFM_F_REF_B];

        fault_n = lv[`DDIFM_F_FLT_NO] || !lv[`DDIFM_F_FLT_NC];
        st_next.ext_fault = fault_n;
        st_next.fault_reset = lv[`DDIFM_F_RST_NO] || !lv[`DDIFM_F_RST_NC];
        // A fault arriving together with a reset stays latched.
        if (fault_n)
        begin
            st_next.fault_latched = 1'b1;
        end
        else if (st_next.fault_reset)
        begin
            st_next.fault_latched = 1'b0;
        end

        st_next.preheat = st_reg.cfg_preheat == `DDIFM_PREHEAT_BY_INPUT
                          && lv[`DDIFM_F_PREHEAT] && st_next.start == 3'h0;
        st_next.ramp_two = lv[`DDIFM_F_RAMP2];
        st_next.ramp_hold = lv[`DDIFM_F_HOLD];
        st_next.preset = preset_lv;
        st_next.pot_up = lv[`DDIFM_F_POT_UP];
        st_next.pot_down = lv[`DDIFM_F_POT_DN];
        st_next.timer_start = timer_lv & ~st_reg.timer_prev;
        st_next.timer_prev = timer_lv;
        st_next.pid_run = st_reg.cfg_pid_en && lv[`DDIFM_F_PID];

        // Read data is captured in the setup cycle so the access phase answers at once.
        if (psel && !penable)
        begin
            st_next.prdata = 32'h0;
            st_next.pslverr = 1'b0;
            if (paddr == `DDIFM_OFF_CFG)
            begin
                st_next.prdata[`DDIFM_CFG_PLACE_LSB +: 2] = st_reg.cfg_place;
                st_next.prdata[`DDIFM_CFG_PREHEAT_LSB +: 2] = st_reg.cfg_preheat;
                st_next.prdata[`DDIFM_CFG_PIDEN_BIT] = st_reg.cfg_pid_en;
            end
            else if (paddr == `DDIFM_OFF_STATUS)
            begin
                st_next.prdata[19:0] = {st_reg.pid_run, st_reg.pot_down, st_reg.pot_up,
                                        st_reg.preset, st_reg.ramp_hold, st_reg.ramp_two,
                                        st_reg.preheat, st_reg.start_blocked, st_reg.ready,
                                        st_reg.fault_reset, st_reg.fault_latched,
                                        st_reg.ext_fault, st_reg.ref_b, st_reg.place,
                                        st_reg.start};
            end
            else if (paddr == `DDIFM_OFF_TERMS)
            begin
                st_next.prdata[`DDIFM_NTERM-1:0] = terms;
            end
            else if (paddr == `DDIFM_OFF_LEVELS)
            begin
                st_next.prdata[`DDIFM_NFUNC-1:0] = lv;
            end
            else if (sel_hit)
            begin
                st_next.prdata[7:0] = st_reg.sel[sel_off[6:2]];
            end
            else
            begin
                st_next.pslverr = 1'b1;
            end
        end

        if (psel && penable && pwrite)
        begin
            if (paddr == `DDIFM_OFF_CFG)
            begin
                st_next.cfg_place = ddifm_place_t'(pwdata[`DDIFM_CFG_PLACE_LSB +: 2]);
                st_next.cfg_preheat = pwdata[`DDIFM_CFG_PREHEAT_LSB +: 2];
                st_next.cfg_pid_en = pwdata[`DDIFM_CFG_PIDEN_BIT];
            end
            else if (sel_hit)
            begin
                st_next.sel[sel_off[6:2]] = pwdata[7:0];
            end
        end

        if (sys_rst)
        begin
            st_next = '0;
            for (int f = 0; f < `DDIFM_NFUNC; f++)
            begin
                st_next.sel[f] = ddifm_dflt_sel(f);
            end
            st_next.cfg_place = ddifm_place_t'(`DDIFM_RST_PLACE);
            st_next.cfg_preheat = `DDIFM_RST_PREHEAT;
            st_next.cfg_pid_en = `DDIFM_RST_PIDEN;
            st_next.timer_prev = `DDIFM_RST_TIMER_PREV;
            st_next.place = DDIFM_PLACE_A;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        st_reg <= st_next;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pready = 1'b1;
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;
    assign start_fwd = st_reg.start[0];
    assign start_rev = st_reg.start[1];
    assign start_third = st_reg.start[2];
    assign cmd_place = st_reg.place;
    assign ref_source_b = st_reg.ref_b;
    assign ext_fault = st_reg.ext_fault;
    assign fault_active = st_reg.fault_latched;
    assign fault_reset = st_reg.fault_reset;
    assign drive_ready = st_reg.ready;
    assign start_blocked = st_reg.start_blocked;
    assign preheat_on = st_reg.preheat;
    assign ramp_set_two = st_reg.ramp_two;
    assign ramp_hold = st_reg.ramp_hold;
    assign preset_index = st_reg.preset;
    assign pot_up = st_reg.pot_up;
    assign pot_down = st_reg.pot_down;
    assign timer_start = st_reg.timer_start;
    assign ext_pid_run = st_reg.pid_run;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking ast_clk @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    AST_DEFAULT_MAP: assert property (
        $past(sys_rst) |-> st_reg.sel[`DDIFM_F_A1] == `DDIFM_SEL_T1
            && st_reg.sel[`DDIFM_F_FLT_NO] == `DDIFM_SEL_T3
            && st_reg.sel[`DDIFM_F_RST_NO] == `DDIFM_SEL_T6)
        else $error("Reset source map is wrong.");

    AST_CONST_FALSE: assert property (
        st_reg.sel[`DDIFM_F_HOLD] == `DDIFM_SEL_OFF |-> !lv[`DDIFM_F_HOLD])
        else $error("Constant false source read true.");

    AST_FWD_A: assert property (
        lv[`DDIFM_F_A1] && st_next.place == DDIFM_PLACE_A && !st_next.start_blocked
            && lv[`DDIFM_F_RUN_EN] |=> start_fwd && cmd_place == DDIFM_PLACE_A)
        else $error("Forward command from place A missing.");

    AST_REV_A: assert property (
        !lv[`DDIFM_F_A2] && st_next.place == DDIFM_PLACE_A |=> !start_rev)
        else $error("Reverse command without its input.");

    AST_FORCE_B: assert property (
        lv[`DDIFM_F_FORCE_B] && !lv[`DDIFM_F_FORCE_KP] && !lv[`DDIFM_F_FORCE_FB]
            |=> cmd_place == DDIFM_PLACE_B)
        else $error("Place B force ignored.");

    AST_KEYPAD: assert property (
        lv[`DDIFM_F_FORCE_KP] |=> cmd_place == DDIFM_PLACE_KEYPAD && !start_fwd)
        else $error("Keypad force ignored.");

    AST_EXT_FAULT: assert property (
        ##1 ext_fault == ($past(lv[`DDIFM_F_FLT_NO]) || !$past(lv[`DDIFM_F_FLT_NC])))
        else $error("External fault level wrong.");

    AST_FAULT_CLEAR: assert property (
        fault_active && st_next.fault_reset && !st_next.ext_fault |=> !fault_active)
        else $error("Fault reset did not clear.");

    AST_BLOCK: assert property (
        !lv[`DDIFM_F_ILK1] |=> start_blocked && {start_third, start_rev, start_fwd} == 3'h0
            && drive_ready == $past(lv[`DDIFM_F_RUN_EN]))
        else $error("Interlock did not block start.");

    AST_PRESET: assert property (
        ##1 preset_index == $past(preset_lv))
        else $error("Preset code wrong.");

    AST_TIMER: assert property (
        $rose(lv[`DDIFM_F_TMR1]) |=> timer_start[0] ##1 !timer_start[0] || $rose(timer_lv[0]))
        else $error("Timer start pulse wrong.");

    AST_PID: assert property (
        !st_reg.cfg_pid_en |=> !ext_pid_run)
        else $error("Process controller ran while disabled.");
endmodule

// file: testbench/ddifm_contacts.sv
// Model of the external switches and contacts wired to the six terminals.
// Assumes the bench sets the contact states right after a rising clock edge.
`timescale 1ns/1ps

module ddifm_contacts
(
    // Commanded contact states, bit 0 is terminal one
    input wire logic [5:0] closed,
    // Terminal levels
    output logic terminal_input_one,
    output logic terminal_input_two,
    output logic terminal_input_three,
    output logic terminal_input_four,
    output logic terminal_input_five,
    output logic terminal_input_six
);
    // --------------------------------
    // Contacts
    // --------------------------------
    // A closed contact reads high; any contact may hold run enable on as long as needed.
    assign {terminal_input_six, terminal_input_five, terminal_input_four} = closed[5:3];
    assign {terminal_input_three, terminal_input_two, terminal_input_one} = closed[2:0];
endmodule

// file: testbench/drive_digital_input_function_map_tb_top.sv
// Self-checking bench for the digital input function map.
// Assumes the design sources and the contacts model are compiled first.
`timescale 1ns/1ps
`include "ddifm_regs.svh"

module drive_digital_input_function_map_tb_top;
    import ddifm_pkg::*;
    // --------------------------------
    // Signals
    // --------------------------------
    typedef struct packed {
        int f;
        logic [7:0] s;
        logic [8:0] c;
        logic [5:0] t;
        logic [22:0] m;
        logic [22:0] e;
    } ddifm_row_t;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er;
    logic [5:0] closed = 6'h00;
    logic terminal_input_one, terminal_input_two, terminal_input_three;
    logic terminal_input_four, terminal_input_five, terminal_input_six;
    logic start_fwd, start_rev, start_third, ref_source_b, ext_fault, fault_active;
    logic fault_reset, drive_ready, start_blocked, preheat_on, ramp_set_two, ramp_hold;
    logic pot_up, pot_down, ext_pid_run;
    ddifm_place_t cmd_place;
    logic [2:0] preset_index, timer_start;
    logic [22:0] ov;
    ddifm_row_t rows[$];
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;

    assign ov = {ext_pid_run, timer_start, pot_down, pot_up, preset_index, ramp_hold,
        ramp_set_two, preheat_on, start_blocked, drive_ready, fault_reset, fault_active,
        ext_fault, ref_source_b, cmd_place, start_third, start_rev, start_fwd};

    ddifm_contacts PARTNER (.closed, .terminal_input_one, .terminal_input_two,
        .terminal_input_three, .terminal_input_four, .terminal_input_five, .terminal_input_six);

    ddifm_top DUT (.ref_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .terminal_input_one, .terminal_input_two, .terminal_input_three,
        .terminal_input_four, .terminal_input_five, .terminal_input_six, .start_fwd,
        .start_rev, .start_third, .cmd_place, .ref_source_b, .ext_fault, .fault_active,
        .fault_reset, .drive_ready, .start_blocked, .preheat_on, .ramp_set_two, .ramp_hold,
        .preset_index, .pot_up, .pot_down, .timer_start, .ext_pid_run);

    // --------------------------------
    // Helpers
    // --------------------------------
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    // The whole run needs under a thousand cycles, so this ceiling only trips on a hang.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // Opens with an edge so that a release and the next setup never share a time step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
        begin
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] sel_addr(input int f);
        return `DDIFM_OFF_SEL_BASE + 12'(4 * f);
    endfunction

    function automatic logic [7:0] dflt(input int f);
        case (f)
            `DDIFM_F_A1: return 8'h11;
            `DDIFM_F_A2: return 8'h12;
            `DDIFM_F_FLT_NO: return 8'h13;
            `DDIFM_F_PS0: return 8'h14;
            `DDIFM_F_PS1: return 8'h15;
            `DDIFM_F_RST_NO: return 8'h16;
            `DDIFM_F_FLT_NC, `DDIFM_F_RST_NC, `DDIFM_F_RUN_EN, `DDIFM_F_ILK1, `DDIFM_F_ILK2,
            `DDIFM_F_PID: return 8'h02;
            default: return 8'h01;
        endcase
    endfunction

    task automatic add(input int f, input logic [7:0] s, input logic [8:0] c,
        input logic [5:0] t, input logic [22:0] m, input logic [22:0] e);
        rows.push_back('{f, s, c, t, m, e});
    endtask

    // --------------------------------
    // Stimulus and checks
    // --------------------------------
    initial
    begin
        add(0, 8'h11, 9'h000, 6'h01, 23'h01C1C3, 23'h000001);
        add(0, 8'h11, 9'h000, 6'h02, 23'h01C1C3, 23'h000002);
        add(0, 8'h11, 9'h000, 6'h04, 23'h01C1C3, 23'h0000C0);
        add(0, 8'h11, 9'h000, 6'h08, 23'h01C1C3, 23'h004080);
        add(0, 8'h11, 9'h000, 6'h10, 23'h01C1C3, 23'h008080);
        add(0, 8'h11, 9'h000, 6'h20, 23'h01C1C3, 23'h000100);
        add(22, 8'h11, 9'h000, 6'h19, 23'h01C000, 23'h01C000);
        add(3, 8'h16, 9'h001, 6'h01, 23'h00001F, 23'h000008);
        add(3, 8'h16, 9'h001, 6'h20, 23'h00001F, 23'h000009);
        add(5, 8'h02, 9'h001, 6'h00, 23'h00001F, 23'h00000C);
        add(6, 8'h12, 9'h000, 6'h02, 23'h00001F, 23'h000008);
        add(8, 8'h11, 9'h000, 6'h01, 23'h00001F, 23'h000018);
        add(9, 8'h02, 9'h000, 6'h01, 23'h00001F, 23'h000010);
        add(7, 8'h14, 9'h000, 6'h08, 23'h000020, 23'h000020);
        add(11, 8'h15, 9'h000, 6'h00, 23'h000040, 23'h000040);
        add(13, 8'h12, 9'h000, 6'h00, 23'h000100, 23'h000100);
        add(13, 8'h12, 9'h000, 6'h02, 23'h000100, 23'h000000);
        add(14, 8'h12, 9'h000, 6'h01, 23'h000201, 23'h000000);
        add(14, 8'h12, 9'h000, 6'h03, 23'h000201, 23'h000201);
        add(15, 8'h01, 9'h000, 6'h01, 23'h000603, 23'h000600);
        add(16, 8'h12, 9'h000, 6'h01, 23'h000603, 23'h000600);
        add(17, 8'h16, 9'h020, 6'h20, 23'h000800, 23'h000800);
        add(17, 8'h16, 9'h010, 6'h20, 23'h000800, 23'h000000);
        add(17, 8'h16, 9'h020, 6'h21, 23'h000800, 23'h000000);
        add(18, 8'h13, 9'h000, 6'h04, 23'h001000, 23'h001000);
        add(19, 8'h02, 9'h000, 6'h00, 23'h002000, 23'h002000);
        add(23, 8'h11, 9'h000, 6'h01, 23'h020000, 23'h020000);
        add(24, 8'h12, 9'h000, 6'h02, 23'h040000, 23'h040000);
        add(28, 8'h11, 9'h100, 6'h00, 23'h400000, 23'h000000);
        add(28, 8'h11, 9'h100, 6'h01, 23'h400000, 23'h400000);
        add(28, 8'h11, 9'h000, 6'h01, 23'h400000, 23'h000000);
        add(0, 8'h01, 9'h000, 6'h01, 23'h000001, 23'h000000);
        repeat (3) @(posedge ref_clk);
        #1 chk("outputs in reset", 32'h0, {9'h0, ov});
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < `DDIFM_NFUNC; i++)
        begin
            apb(1'b0, sel_addr(i), 32'h0);
            chk($sformatf("selector %0d", i), {24'h0, dflt(i)}, {24'h0, rd[7:0]});
        end
        apb(1'b0, `DDIFM_OFF_CFG, 32'h0);
        chk("cfg reset", 32'h0, rd);
        apb(1'b1, `DDIFM_OFF_CFG, 32'h131);
        apb(1'b0, `DDIFM_OFF_CFG, 32'h0);
        chk("cfg readback", 32'h131, rd);
        apb(1'b1, 12'h0FC, 32'h1);
        chk("unmapped write", 32'h1, {31'h0, er});
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped read", 32'h1, {31'h0, er});
        foreach (rows[i])
        begin
            apb(1'b1, `DDIFM_OFF_CFG, {23'h0, rows[i].c});
            apb(1'b1, sel_addr(rows[i].f), {24'h0, rows[i].s});
            closed <= rows[i].t;
            repeat (2) @(posedge ref_clk);
            #1 chk($sformatf("row %0d", i), {9'h0, rows[i].e}, {9'h0, ov & rows[i].m});
            apb(1'b1, sel_addr(rows[i].f), {24'h0, dflt(rows[i].f)});
        end
        closed <= 6'h00;
        for (int i = 25; i < 28; i++)
        begin
            apb(1'b1, sel_addr(i), 32'h11);
        end
        closed <= 6'h01;
        @(posedge ref_clk);
        #1 chk("timer pulse", 32'h7, {29'h0, timer_start});
        @(posedge ref_clk);
        #1 chk("timer level", 32'h0, {29'h0, timer_start});
        apb(1'b0, `DDIFM_OFF_TERMS, 32'h0);
        chk("terminal levels", 32'h1, rd);
        chk("terminal levels error", 32'h0, {31'h0, er});
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        #1 chk("outputs in second reset", 32'h0, {9'h0, ov});
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, sel_addr(25), 32'h0);
        chk("timer selector after reset", 32'h1, rd);
        final_report();
    end
endmodule
